/* src/mode_settings_pkg.sv */
// Mode settings package: bit layout, codes and timing for the mode-load decode.
// Assumes a command decoder upstream that flags mode-load, read, write and self refresh.
package mode_settings_pkg;

    // ************************************************
    // Register layout
    // ************************************************
    localparam int REG_W = 17; // Width of both settings registers
    localparam int BANK_W = 3; // Bank address width
    localparam logic [2:0] BANK_MODE = 3'h0; // Selects the mode settings register
    localparam logic [2:0] BANK_EXT = 3'h1; // Selects the extended settings register

    localparam int BL_LSB = 0; // Burst length field
    localparam int BO_BIT = 3; // Burst order
    localparam int RLAT_LSB = 4; // Read latency field
    localparam int TEST_BIT = 7; // Test mode
    localparam int DLLRST_BIT = 8; // DLL reset
    localparam int WR_LSB = 9; // Write recovery field
    localparam int PDX_BIT = 12; // Power-down exit
    localparam int DLLDIS_BIT = 0; // DLL disable
    localparam int DRV_BIT = 1; // Drive strength
    localparam int AL_LSB = 3; // Additive latency field
    localparam int SCD_BIT = 10; // Strobe complement disable
    localparam int RSC_BIT = 11; // Read strobe copy enable
    localparam int ODIS_BIT = 12; // Output disable

    // ************************************************
    // Codes and reset values
    // ************************************************
    localparam logic [2:0] BL_FOUR = 3'h2; // Burst of four
    localparam logic [2:0] BL_EIGHT = 3'h3; // Burst of eight
    localparam logic [2:0] RLAT_MIN = 3'h3; // Lowest legal read latency
    localparam logic [2:0] RLAT_MAX = 3'h7; // Highest legal read latency
    localparam logic [2:0] WR_CODE_MIN = 3'h1; // Code for two clocks
    localparam logic [2:0] WR_CODE_MAX = 3'h7; // Code for eight clocks
    localparam logic [2:0] AL_MAX = 3'h6; // Highest additive latency
    localparam logic [16:0] MODE_RESET = 17'h00232; // Burst 4, latency 3, recovery 2
    localparam logic [16:0] EXT_RESET = 17'h00000; // DLL on, full drive, outputs and complement on, copy off
    localparam logic [3:0] ONE4 = 4'h1; // Unit step for latency arithmetic
    localparam logic [3:0] WR_STEP = 4'h1; // Code to clocks offset

    // ************************************************
    // Timing
    // ************************************************
    localparam int CLK_MHZ = 125; // Memory clock rate
    localparam int DLL_LOCK_CLKS = 200; // Settle cycles after DLL reset
    localparam logic [7:0] DLL_LOCK_CNT = 8'(DLL_LOCK_CLKS); // Counter load

    // ************************************************
    // Carriers
    // ************************************************
    typedef struct packed {
        logic load; // Mode-load strobe
        logic [2:0] bank; // Register select
        logic [16:0] addr; // Value to load
    } mode_load_t;

    typedef struct packed {
        logic [3:0] total_read_latency; // Additive plus read latency
        logic [3:0] total_write_latency; // One below read latency
        logic [3:0] write_recovery; // Clocks before auto precharge
        logic eight_burst; // Burst of eight
        logic interleaved; // Interleaved order
        logic slow_exit; // Slow exit active power-down
        logic full_drive; // Full drive strength
        logic outputs_on; // Data and strobes enabled
        logic comp_on; // Strobe complement driven
        logic copy_on; // Read strobe copy driven
        logic copy_comp_on; // Copy complement driven
    } decoded_t;

    typedef enum logic [1:0] {
        DLL_ON = 2'b00, // Running and locked
        DLL_LOCKING = 2'b01, // Counting settle cycles
        DLL_HELD = 2'b11 // Off, by bit or self refresh
    } dll_state_t;

endpackage

/* src/sdram_mode_settings_decode.sv */
// Mode settings register bank with its decode into operating controls.
// Assumes an upstream command decoder on mclk presenting one-cycle strobes.
`timescale 1ns/1ps

// How it works
// R1 - Test mode bit set leaves others unchanged
// R2 - DLL reset bit starts reset, self-clears
// R3 - Auto precharge waits recovery after last data
// R4 - Controller programs recovery 2 to 8
// R5 - Exit bit zero: fast exit, DLL running
// R6 - Exit bit one: slow exit, DLL frozen
// R7 - Exit bit ignored in precharge power-down
// R8 - Read latency 3 to 7 whole clocks
// R9 - First read data at edge n+m
// R10 - Early read delayed by additive latency
// R11 - Controller loads extended only when idle
// R12 - Extended register holds until reloaded
// R13 - Controller enables DLL then resets it
// R14 - Self refresh stops DLL, exit resets it
// R15 - Controller waits 200 clocks before read
// R16 - Slow clock, DLL off: precharge after refresh
// R17 - Drive bit selects full or reduced
// R18 - Complement strobe inverse or disabled
// R19 - Copy strobe follows reads, ignored writes
// R20 - Copy complement driven with complement enabled
// R21 - Output disable bit turns outputs off
// R22 - Controller writes zero above bit 12
// R23 - Burst length four or eight
// R24 - Burst order sequential or interleaved
// R25 - Read is additive plus field; write one less
// R26 - Bank address routes load to register
module sdram_mode_settings_decode (
    input wire logic mclk, // Memory clock
    input wire logic reset, // Synchronous, active high
    input wire mode_settings_pkg::mode_load_t load_in, // Mode-load command
    input wire logic read_cmd, // Read registered this edge
    input wire logic write_ap_done, // Last data of auto-precharge write
    input wire logic active_pd_enter, // Entering active power-down
    input wire logic precharge_pd_enter, // Entering precharge power-down
    input wire logic pd_exit, // Leaving any power-down
    input wire logic self_refresh_enter, // Entering self refresh
    input wire logic self_refresh_exit, // Leaving self refresh
    input wire logic byte_wide, // Part is byte wide
    input wire logic write_active, // A write burst is on the bus
    output mode_settings_pkg::decoded_t decoded, // Decoded settings
    output logic [16:0] mode_settings_reg, // Mode settings contents
    output logic [16:0] extended_settings_reg, // Extended settings contents
    output logic dll_reset_pulse, // One-cycle DLL reset start
    output logic dll_running, // DLL enabled and not frozen
    output logic dll_locked, // Settle period over
    output logic read_issue, // Internal read after additive latency; none when it is 0
    output logic read_data_start, // First read data edge
    output logic precharge_fire, // Internal auto precharge
    output logic slow_exit_active, // Current power-down is slow exit
    output logic in_active_pd, // Active power-down in effect
    output logic in_precharge_pd, // Precharge power-down in effect
    output logic copy_strobe_drive // Copy strobe drives this cycle
);

    // ************************************************
    // Settings registers
    // ************************************************
    logic [16:0] mode_r; // Mode settings storage
    logic [16:0] ext_r; // Extended settings storage
    logic test_bit; // Incoming test mode bit

    assign test_bit = load_in.addr[mode_settings_pkg::TEST_BIT];

    // Mode settings load; test mode writes nothing else
    always_ff @(posedge mclk) begin
        if (reset) begin
            mode_r <= mode_settings_pkg::MODE_RESET;
        end else if (load_in.load && load_in.bank == mode_settings_pkg::BANK_MODE) begin // R26
            if (test_bit) begin
                mode_r[mode_settings_pkg::TEST_BIT] <= 1'b1; // R1
            end else begin
                mode_r <= load_in.addr;
            end
        end else begin
            mode_r[mode_settings_pkg::DLLRST_BIT] <= 1'b0; // R2
        end
    end

    // Extended settings hold until the next load to this bank
    always_ff @(posedge mclk) begin
        if (reset) begin
            ext_r <= mode_settings_pkg::EXT_RESET;
        end else if (load_in.load && load_in.bank == mode_settings_pkg::BANK_EXT) begin // R26
            ext_r <= load_in.addr; // R12
        end
    end

    // ************************************************
    // Field decode
    // ************************************************
    logic [2:0] rlat_code; // Read latency field
    logic [2:0] wr_code; // Write recovery field
    logic [2:0] al_code; // Additive latency field
    logic [3:0] rlat_clks; // Read latency clamped to legal range
    logic [3:0] al_clks; // Additive latency clamped
    logic [3:0] total_rl; // Total read latency
    logic [3:0] wr_clks; // Recovery clocks
    logic comp_en; // Strobe complement enabled
    logic copy_en; // Read strobe copy enabled
    logic out_en; // Outputs enabled

    assign rlat_code = mode_r[mode_settings_pkg::RLAT_LSB +: 3];
    assign wr_code = mode_r[mode_settings_pkg::WR_LSB +: 3];
    assign al_code = ext_r[mode_settings_pkg::AL_LSB +: 3];
    // Reserved codes clamp to the nearest legal value rather than misbehave
    assign rlat_clks = {1'b0, (rlat_code < mode_settings_pkg::RLAT_MIN) ? mode_settings_pkg::RLAT_MIN
        : rlat_code}; // R8
    assign al_clks = {1'b0, (al_code > mode_settings_pkg::AL_MAX) ? mode_settings_pkg::AL_MAX : al_code}; // R10
    assign total_rl = 4'(al_clks + rlat_clks); // R25
    assign wr_clks = 4'({1'b0, (wr_code < mode_settings_pkg::WR_CODE_MIN) ? mode_settings_pkg::WR_CODE_MIN
        : wr_code} + mode_settings_pkg::WR_STEP); // R4
    assign comp_en = ~ext_r[mode_settings_pkg::SCD_BIT]; // R18
    assign copy_en = ext_r[mode_settings_pkg::RSC_BIT] & byte_wide; // R19
    assign out_en = ~ext_r[mode_settings_pkg::ODIS_BIT]; // R21

    // Registered decode, so every output leaves a flip-flop
    always_ff @(posedge mclk) begin
        if (reset) begin
            decoded <= '0;
            mode_settings_reg <= mode_settings_pkg::MODE_RESET;
            extended_settings_reg <= mode_settings_pkg::EXT_RESET;
        end else begin
            mode_settings_reg <= mode_r;
            extended_settings_reg <= ext_r;
            decoded.total_read_latency <= total_rl; // R25
            decoded.total_write_latency <= 4'(total_rl - mode_settings_pkg::ONE4); // R25
            decoded.write_recovery <= wr_clks; // R3
            decoded.eight_burst <= mode_r[mode_settings_pkg::BL_LSB +: 3] == mode_settings_pkg::BL_EIGHT; // R23
            decoded.interleaved <= mode_r[mode_settings_pkg::BO_BIT]; // R24
            decoded.slow_exit <= mode_r[mode_settings_pkg::PDX_BIT];
            decoded.full_drive <= ~ext_r[mode_settings_pkg::DRV_BIT]; // R17
            decoded.outputs_on <= out_en; // R21
            decoded.comp_on <= comp_en & out_en; // R18
            decoded.copy_on <= copy_en & out_en; // R19
            decoded.copy_comp_on <= copy_en & comp_en & out_en; // R20
        end
    end

    // ************************************************
    // DLL control
    // ************************************************
    mode_settings_pkg::dll_state_t dll_r; // DLL state
    logic [7:0] lock_cnt_r; // Settle counter
    logic dll_rst_req; // A reset request this cycle

    // Reset from a load with the bit set, or from leaving self refresh
    assign dll_rst_req = (load_in.load && load_in.bank == mode_settings_pkg::BANK_MODE && !test_bit
        && load_in.addr[mode_settings_pkg::DLLRST_BIT]) || self_refresh_exit; // R2 R14

    // Self refresh entry wins; the disable bit holds the DLL off
    always_ff @(posedge mclk) begin
        if (reset) begin
            dll_r <= mode_settings_pkg::DLL_LOCKING;
            lock_cnt_r <= mode_settings_pkg::DLL_LOCK_CNT;
        end else if (self_refresh_enter || ext_r[mode_settings_pkg::DLLDIS_BIT]) begin
            dll_r <= mode_settings_pkg::DLL_HELD; // R14
            lock_cnt_r <= mode_settings_pkg::DLL_LOCK_CNT;
        end else if (dll_rst_req) begin
            dll_r <= mode_settings_pkg::DLL_LOCKING; // R2
            lock_cnt_r <= mode_settings_pkg::DLL_LOCK_CNT;
        end else begin
            unique case (dll_r)
                mode_settings_pkg::DLL_LOCKING: begin
                    if (lock_cnt_r == 8'h01) begin
                        dll_r <= mode_settings_pkg::DLL_ON;
                    end
                    lock_cnt_r <= 8'(lock_cnt_r - 8'h01);
                end
                mode_settings_pkg::DLL_HELD: begin
                    // Stays off until a DLL reset or self refresh exit restarts it
                    dll_r <= mode_settings_pkg::DLL_HELD; // R14
                end
                mode_settings_pkg::DLL_ON: begin
                    lock_cnt_r <= lock_cnt_r;
                end
            endcase
        end
    end

    // Reset pulse and lock status
    always_ff @(posedge mclk) begin
        if (reset) begin
            dll_reset_pulse <= 1'b0;
            dll_locked <= 1'b0;
        end else begin
            dll_reset_pulse <= dll_rst_req & ~self_refresh_enter; // R2
            dll_locked <= dll_r == mode_settings_pkg::DLL_ON;
        end
    end

    // ************************************************
    // Power-down style
    // ************************************************
    // Exit bit sampled at active entry only; precharge entry never looks at it
    always_ff @(posedge mclk) begin
        if (reset) begin
            in_active_pd <= 1'b0;
            in_precharge_pd <= 1'b0;
            slow_exit_active <= 1'b0;
        end else if (pd_exit) begin
            in_active_pd <= 1'b0;
            in_precharge_pd <= 1'b0;
            slow_exit_active <= 1'b0;
        end else if (active_pd_enter) begin
            in_active_pd <= 1'b1;
            slow_exit_active <= mode_r[mode_settings_pkg::PDX_BIT]; // R5 R6
        end else if (precharge_pd_enter) begin
            in_precharge_pd <= 1'b1; // R7
            slow_exit_active <= 1'b0; // R7
        end
    end

    // DLL frozen only in slow-exit active power-down
    always_ff @(posedge mclk) begin
        if (reset) begin
            dll_running <= 1'b0;
        end else begin
            dll_running <= dll_r != mode_settings_pkg::DLL_HELD && !(in_active_pd && slow_exit_active); // R5 R6
        end
    end

    // ************************************************
    // Read timing
    // ************************************************
    // Shift lines; bit k set means the event is k+1 edges away
    logic [15:0] issue_sr_r; // Additive latency line
    logic [15:0] data_sr_r; // Total latency line

    // Both lines load at the read edge; outputs are the registered bit 0, except read_issue, taken directly at additive latency 1 and never raised at 0
    always_ff @(posedge mclk) begin
        if (reset) begin
            issue_sr_r <= '0;
            data_sr_r <= '0;
            read_issue <= 1'b0;
            read_data_start <= 1'b0;
        end else begin
            issue_sr_r <= {1'b0, issue_sr_r[15:1]} | (read_cmd && al_clks > 4'h1 ?
                16'(16'h0001 << 4'(al_clks - 4'h2)) : 16'h0000); // R10
            data_sr_r <= {1'b0, data_sr_r[15:1]} | (read_cmd ? 16'(16'h0001 << 4'(total_rl - 4'h2))
                : 16'h0000); // R9
            read_issue <= (read_cmd && al_clks == 4'h0) ? 1'b0 : (read_cmd && al_clks == 4'h1) | issue_sr_r[0];
            read_data_start <= data_sr_r[0]; // R9
        end
    end

    // ************************************************
    // Auto precharge after write recovery
    // ************************************************
    logic [3:0] wr_cnt_r; // Recovery countdown, zero when idle

    // Countdown from the last data; fires once when it ends
    always_ff @(posedge mclk) begin
        if (reset) begin
            wr_cnt_r <= 4'h0;
            precharge_fire <= 1'b0;
        end else begin
            precharge_fire <= wr_cnt_r == 4'h2; // R3
            if (write_ap_done) begin
                wr_cnt_r <= wr_clks; // R3
            end else if (wr_cnt_r != 4'h0) begin
                wr_cnt_r <= 4'(wr_cnt_r - 4'h1);
            end
        end
    end

    // ************************************************
    // Copy strobe
    // ************************************************
    // Drives only while reading; a write never turns it on
    always_ff @(posedge mclk) begin
        if (reset) begin
            copy_strobe_drive <= 1'b0;
        end else begin
            copy_strobe_drive <= copy_en & out_en & data_sr_r[0] & ~write_active; // R19
        end
    end

endmodule

/* verif/sdram_mode_settings_decode_sva.sv */
// Checker for the mode settings decode, watching only its top ports.
// Assumes one mclk domain with a synchronous active high reset.
`timescale 1ns/1ps
module sdram_mode_settings_decode_sva (
    input wire logic mclk,
    input wire logic reset,
    input wire mode_settings_pkg::mode_load_t load_in,
    input wire logic read_cmd,
    input wire logic write_ap_done,
    input wire mode_settings_pkg::decoded_t decoded,
    input wire logic [16:0] mode_settings_reg,
    input wire logic [16:0] extended_settings_reg,
    input wire logic dll_reset_pulse,
    input wire logic read_issue,
    input wire logic read_data_start,
    input wire logic precharge_fire,
    input wire logic slow_exit_active,
    input wire logic in_precharge_pd
);
    // ******
    // Helpers
    // ******
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    logic ld_mode; // Load aimed at mode settings
    logic ld_ext; // Load aimed at extended settings
    assign ld_mode = load_in.load && load_in.bank == mode_settings_pkg::BANK_MODE;
    assign ld_ext = load_in.load && load_in.bank == mode_settings_pkg::BANK_EXT;
    // ******
    // Timing relations
    // ******
    // Copies lag storage one edge
    property p_test_keep; ld_mode && load_in.addr[7] |-> ##2 mode_settings_reg[7]
        && mode_settings_reg[6:0] == $past(mode_settings_reg[6:0]); endproperty
    a_test_keep: assert property (p_test_keep) else $error("test bit load");
    property p_dll_rst; ld_mode && !load_in.addr[7] && load_in.addr[8] |=> dll_reset_pulse ##2
        !mode_settings_reg[8]; endproperty
    a_dll_rst: assert property (p_dll_rst) else $error("dll reset");
    property p_ext_route; ld_ext |-> ##2 extended_settings_reg == $past(load_in.addr, 2); endproperty
    a_ext_route: assert property (p_ext_route) else $error("ext store");
    property p_lat3; read_cmd && decoded.total_read_latency == 4'h3 |-> ##3 read_data_start; endproperty
    a_lat3: assert property (p_lat3) else $error("latency 3");
    property p_lat7; read_cmd && decoded.total_read_latency == 4'h7 |-> ##7 read_data_start; endproperty
    a_lat7: assert property (p_lat7) else $error("latency 7");
    property p_al2; read_cmd && extended_settings_reg[5:3] == 3'h2 |-> ##2 read_issue; endproperty
    a_al2: assert property (p_al2) else $error("additive latency");
    property p_wr2; write_ap_done && decoded.write_recovery == 4'h2 |-> ##2 precharge_fire; endproperty
    a_wr2: assert property (p_wr2) else $error("recovery 2");
    property p_wr8; write_ap_done && decoded.write_recovery == 4'h8 |-> ##8 precharge_fire; endproperty
    a_wr8: assert property (p_wr8) else $error("recovery 8");
    // Zero only just after reset
    property p_wlat; decoded.total_read_latency != 4'h0 |->
        decoded.total_write_latency == decoded.total_read_latency - 4'h1; endproperty
    a_wlat: assert property (p_wlat) else $error("write latency");
    property p_ppd; in_precharge_pd |-> !slow_exit_active; endproperty
    a_ppd: assert property (p_ppd) else $error("precharge pd");
endmodule
bind sdram_mode_settings_decode sdram_mode_settings_decode_sva u_sdram_mode_settings_decode_sva (.*);

/* verif/sdram_ctrl_model.sv */
// Controller model: mode-loads and one-cycle command strobes.
// Assumes its tasks are called from one bench process on mclk.
`timescale 1ns/1ps
module sdram_ctrl_model #(
    parameter int MODE_GAP = 2 // Idle edges after a mode-load
) (
    input wire logic mclk,
    output mode_settings_pkg::mode_load_t load_in,
    output logic [6:0] cmd // Read, wap done, apd, ppd, pd exit, sr in, sr out
);
    int since_dll = 0; // Cycles since the last DLL reset
    always @(posedge mclk) since_dll <= since_dll + 1;
    // Clock is 125 MHz, so no precharge-all is owed after refresh
    initial begin
        load_in = '0;
        cmd = '0;
    end
    // Clocks to write recovery code, legal range 2 to 8 only
    function automatic logic [2:0] wr_code(input int clocks);
        return 3'(clocks - 1);
    endfunction
    // One-cycle strobe on a command line
    task automatic strobe(input int idx);
        @(posedge mclk);
        #1;
        cmd[idx] = 1'b1;
        @(posedge mclk);
        #1;
        cmd[idx] = 1'b0;
        if (idx == 6) since_dll = 0;
    endtask
    // Read held back until the DLL has settled
    task automatic read();
        while (since_dll < 200) @(posedge mclk);
        strobe(0);
    endtask
    // Mode-load, bus idle; then the load gap
    task automatic load(input logic [2:0] bank, input logic [16:0] value);
        @(posedge mclk);
        #1;
        load_in = {1'b1, bank, value & 17'h01FFF};
        @(posedge mclk);
        #1;
        load_in = {1'b0, ~bank, ~value}; // Released lines carry no stale value
        if (bank == mode_settings_pkg::BANK_MODE && value[8]) since_dll = 0;
        repeat (MODE_GAP) @(posedge mclk);
        #1;
    endtask
    // DLL enable is always followed by a DLL reset
    task automatic dll_enable(input logic [16:0] mode);
        load(mode_settings_pkg::BANK_EXT, 17'h00000);
        load(mode_settings_pkg::BANK_MODE, mode | 17'h00100);
    endtask
endmodule

/* verif/sdram_mode_settings_decode_tb.sv */
// Self-checking bench for the mode settings decode.
// Assumes the controller model drives loads and strobes; checker is bound.
`timescale 1ns/1ps
module sdram_mode_settings_decode_tb;
    localparam logic [2:0] MB = mode_settings_pkg::BANK_MODE; // Mode bank
    localparam logic [2:0] EB = mode_settings_pkg::BANK_EXT; // Extended bank
    logic mclk = 1'b0; // 125 MHz clock
    logic reset = 1'b1; // Sync reset
    logic byte_wide = 1'b1; // Byte-wide part
    logic write_active = 1'b0; // No write burst
    mode_settings_pkg::mode_load_t load_in;
    logic [6:0] cmd;
    mode_settings_pkg::decoded_t decoded;
    logic [16:0] mode_settings_reg, extended_settings_reg;
    logic dll_reset_pulse, dll_running, dll_locked, read_issue, read_data_start, precharge_fire;
    logic slow_exit_active, in_active_pd, in_precharge_pd, copy_strobe_drive;
    logic [3:0] seen; // Pulses timed by cycles_to
    int mismatches = 0;
    int n_checks = 0;
    int n;
    assign seen = {dll_reset_pulse, precharge_fire, read_issue, read_data_start};
    sdram_mode_settings_decode u_sdram_mode_settings_decode (.mclk(mclk), .reset(reset), .load_in(load_in),
        .read_cmd(cmd[0]), .write_ap_done(cmd[1]), .active_pd_enter(cmd[2]), .precharge_pd_enter(cmd[3]),
        .pd_exit(cmd[4]), .self_refresh_enter(cmd[5]), .self_refresh_exit(cmd[6]), .byte_wide(byte_wide),
        .write_active(write_active), .decoded(decoded), .mode_settings_reg(mode_settings_reg),
        .extended_settings_reg(extended_settings_reg), .dll_reset_pulse(dll_reset_pulse),
        .dll_running(dll_running), .dll_locked(dll_locked), .read_issue(read_issue),
        .read_data_start(read_data_start), .precharge_fire(precharge_fire), .slow_exit_active(slow_exit_active),
        .in_active_pd(in_active_pd), .in_precharge_pd(in_precharge_pd), .copy_strobe_drive(copy_strobe_drive));
    sdram_ctrl_model u_sdram_ctrl_model (.mclk(mclk), .load_in(load_in), .cmd(cmd));
    // ******
    // Tasks
    // ******
    task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Cycles from a command edge to a pulse, capped against a hang
    task automatic cycles_to(input int idx, output int cnt);
        cnt = 1;
        while (seen[idx] !== 1'b1 && cnt < 300) begin
            @(posedge mclk);
            #1;
            cnt++;
        end
    endtask
    task automatic stop_test();
        if (mismatches == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial forever #4 mclk = ~mclk;
    // Watchdog past the expected run
    initial begin
        #200000;
        mismatches++;
        stop_test();
    end
    // ******
    // Scenarios
    // ******
    initial begin
        repeat (4) @(posedge mclk);
        #1;
        reset = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        check("mode reset", 17'h00232, mode_settings_reg);
        check("ext reset", 17'h00000, extended_settings_reg);
        // Every legal read latency, no additive latency
        for (int cl = 3; cl <= 7; cl++) begin
            u_sdram_ctrl_model.load(MB, {8'h02, 1'b0, 1'b0, 3'(cl), 1'b0, 3'h2});
            check("read latency", 17'(cl), 17'(decoded.total_read_latency));
            check("write latency", 17'(cl - 1), 17'(decoded.total_write_latency));
            u_sdram_ctrl_model.read();
            cycles_to(0, n);
            check("first data", 17'(cl), 17'(n));
        end
        // Every write recovery count, boundaries included
        for (int wr = 2; wr <= 8; wr++) begin
            u_sdram_ctrl_model.load(MB, {4'h0, 1'b0, u_sdram_ctrl_model.wr_code(wr), 6'h06, 3'h3});
            check("recovery", 17'(wr), 17'(decoded.write_recovery));
            u_sdram_ctrl_model.strobe(1);
            cycles_to(2, n);
            check("precharge delay", 17'(wr), 17'(n));
        end
        check("burst", 17'h2, {15'h0, decoded.eight_burst, decoded.interleaved});
        u_sdram_ctrl_model.load(MB, 17'h0009C);
        check("test mode", 17'h00EB3, mode_settings_reg);
        u_sdram_ctrl_model.load(MB, 17'h00F3B);
        repeat (2) @(posedge mclk);
        #1;
        check("dll bit cleared", 17'h00E3B, mode_settings_reg);
        check("interleave", 17'h1, 17'(decoded.interleaved));
        // Extended: additive 2, reduced drive, copy strobe on
        u_sdram_ctrl_model.load(EB, 17'h00812);
        check("ext store", 17'h00812, extended_settings_reg);
        check("strobes", 17'h7, {13'h0, decoded.full_drive, decoded.comp_on, decoded.copy_on,
            decoded.copy_comp_on});
        write_active = 1'b1;
        u_sdram_ctrl_model.read();
        cycles_to(1, n);
        check("internal read", 17'h2, 17'(n));
        cycles_to(0, n);
        check("copy in write", 17'h0, 17'(copy_strobe_drive));
        write_active = 1'b0;
        u_sdram_ctrl_model.read();
        cycles_to(0, n);
        check("first data al", 17'h5, 17'(n));
        check("copy strobe", 17'h1, 17'(copy_strobe_drive));
        u_sdram_ctrl_model.load(EB, 17'h00C12);
        check("single ended", 17'h2, {15'h0, decoded.comp_on, decoded.copy_on, decoded.copy_comp_on});
        u_sdram_ctrl_model.load(3'h2, 17'h01FFF);
        check("ext held", 17'h00C12, extended_settings_reg);
        u_sdram_ctrl_model.load(EB, 17'h01C12);
        check("outputs off", 17'h0, 17'(decoded.outputs_on));
        // Power-down: fast, slow, then precharge with slow bit set
        u_sdram_ctrl_model.strobe(2);
        check("fast exit", 17'h5, {14'h0, in_active_pd, slow_exit_active, dll_running});
        u_sdram_ctrl_model.strobe(4);
        u_sdram_ctrl_model.load(MB, 17'h01E3B);
        u_sdram_ctrl_model.strobe(2);
        check("slow exit", 17'h3, {15'h0, in_active_pd, slow_exit_active});
        u_sdram_ctrl_model.strobe(4);
        u_sdram_ctrl_model.strobe(3);
        check("precharge pd", 17'h2, {15'h0, in_precharge_pd, slow_exit_active});
        u_sdram_ctrl_model.strobe(4);
        // Self refresh stops the DLL; exit resets and relocks it
        u_sdram_ctrl_model.strobe(5);
        #8;
        check("dll off in sr", 17'h0, 17'(dll_running));
        u_sdram_ctrl_model.strobe(6);
        cycles_to(3, n);
        check("dll reset on exit", 17'h1, 17'(n));
        #1520;
        check("still locking", 17'h0, 17'(dll_locked));
        #120;
        check("locked", 17'h1, 17'(dll_locked));
        u_sdram_ctrl_model.load(EB, 17'h00001);
        check("dll disabled", 17'h0, 17'(dll_running));
        u_sdram_ctrl_model.dll_enable(17'h00232);
        check("dll enabled", 17'h1, 17'(dll_running));
        stop_test();
    end
endmodule
